// file: rtl/lusld_core.sv
// Decode and execute of loads and left shifts
// Summary of operation
// - Index register shifted, carry flag as input
// - Offset address is base plus or minus offset
// - Index set uses offset address, else base
// - Writeback puts offset address into base
// - Halfword loads sign-extend two bytes to 32
// - Unprivileged loads access with user permissions
// - Unprivileged address base plus byte, no writeback
// - Unprivileged half load fetches two bytes, extends
// - All-ones base on half form means literal
// - All-ones base on word form means literal
// - Wide forms undefined without main extension
// - Immediate shift fills low bits with zeros
// - Narrow count field 1..31, zero not shift
// - Wide count joins 3-bit and 2-bit fields
// - Register count uses low byte, zero fill
// - Flag-setting forms update N, Z, C
`timescale 1ns/100ps
module lusld_core
    import lusld_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    input  wire logic        instr_is_32,
    input  wire logic [31:0] instr_pc,
    input  wire logic        cond_pass,
    input  wire logic        in_it_block,
    input  wire logic        main_extension_present,
    output logic             instr_ready,
    // Register file reads
    output logic [3:0]       rf_addr_a,
    output logic [3:0]       rf_addr_b,
    input  wire logic [31:0] rf_data_a,
    input  wire logic [31:0] rf_data_b,
    input  wire logic        carry_flag,
    // Register file writes
    output logic             rd_we,
    output logic [3:0]       rd_addr,
    output logic [31:0]      rd_data,
    output logic             wb_we,
    output logic [3:0]       wb_addr,
    output logic [31:0]      wb_data,
    // Condition flags
    output logic             flag_we,
    output logic             flag_n,
    output logic             flag_z,
    output logic             flag_c,
    // Memory port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_word,
    output logic             mem_unpriv,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // Completion
    output logic             done,
    output logic             undef,
    output logic             foreign
);
    lusld_dec_if  dif ();            // Decoder results
    lusld_state_e st_reg;            // Sequencer state
    lusld_state_e st_next;
    logic [31:0]  ins_reg;           // Captured instruction
    logic [31:0]  ins_next;
    logic         is32_reg;          // Captured width
    logic         is32_next;
    logic [31:0]  pc_reg;            // Captured pc value
    logic [31:0]  pc_next;
    logic         cond_reg;          // Captured condition result
    logic         cond_next;
    logic         it_reg;            // Captured IT state
    logic         it_next;
    logic         mext_reg;          // Captured extension strap
    logic         mext_next;
    logic [31:0]  off_addr_reg;      // Kept for writeback
    logic [31:0]  off_addr_next;
    logic [31:0]  sh_in;             // Shifter operand
    logic [7:0]   sh_amt;            // Shifter count
    logic [31:0]  sh_out;            // Shifter result
    logic         sh_c;              // Shifter carry out
    logic [31:0]  base;              // Base address
    logic [31:0]  offset;            // Byte offset
    logic [31:0]  off_addr;          // Base with offset applied
    // Registered outputs and their next values
    logic        rdy_reg, rdy_next;
    logic [3:0]  ra_reg, ra_next, rb_reg, rb_next;
    logic        rdwe_reg, rdwe_next;
    logic [3:0]  rda_reg, rda_next, wba_reg, wba_next;
    logic [31:0] rdd_reg, rdd_next, wbd_reg, wbd_next;
    logic        wbwe_reg, wbwe_next;
    logic        fwe_reg, fwe_next;
    logic        fn_reg, fn_next, fz_reg, fz_next, fc_reg, fc_next;
    logic        mreq_reg, mreq_next;
    logic [31:0] madr_reg, madr_next;
    logic        mw_reg, mw_next, mu_reg, mu_next;
    logic        done_reg, done_next, und_reg, und_next;
    logic        frn_reg, frn_next;

    // Decodes the captured word
    lusld_decode u_dec (
        .instr       (ins_reg),
        .is_32       (is32_reg),
        .in_it_block (it_reg),
        .main_ext    (mext_reg),
        .d           (dif)
    );

    // Shared shifter
    lusld_shifter u_sh (
        .value     (sh_in),
        .amount    (sh_amt),
        .carry_in  (carry_flag),
        .result    (sh_out),
        .carry_out (sh_c)
    );

    // Address arithmetic for execute
    always_comb begin
        // Loads shift the index, shifts the source
        sh_in  = (dif.kind == K_LOAD) ? rf_data_b : rf_data_a;
        sh_amt = dif.reg_amount ? rf_data_b[7:0]
                                : {3'h0, dif.amount};
        base   = dif.literal ? (pc_reg & ALIGN_MSK) : rf_data_a;
        offset = dif.use_imm ? {20'h00000, dif.imm} : sh_out;
        off_addr = dif.add ? (base + offset) : (base - offset);
    end

    // Sequencer and output next values
    always_comb begin
        st_next = st_reg;
        ins_next = ins_reg;
        is32_next = is32_reg;
        pc_next = pc_reg;
        cond_next = cond_reg;
        it_next = it_reg;
        mext_next = mext_reg;
        off_addr_next = off_addr_reg;
        rdy_next = rdy_reg;
        ra_next = ra_reg;
        rb_next = rb_reg;
        rdwe_next = 1'b0;
        rda_next = rda_reg;
        rdd_next = rdd_reg;
        wbwe_next = 1'b0;
        wba_next = wba_reg;
        wbd_next = wbd_reg;
        fwe_next = 1'b0;
        fn_next = fn_reg;
        fz_next = fz_reg;
        fc_next = fc_reg;
        mreq_next = mreq_reg;
        madr_next = madr_reg;
        mw_next = mw_reg;
        mu_next = mu_reg;
        done_next = 1'b0;
        und_next = 1'b0;
        frn_next = 1'b0;
        unique case (st_reg)
            ST_IDLE: begin
                // Capture the instruction
                if (instr_valid) begin
                    ins_next  = instr_word;
                    is32_next = instr_is_32;
                    pc_next   = instr_pc;
                    cond_next = cond_pass;
                    it_next   = in_it_block;
                    mext_next = main_extension_present;
                    rdy_next  = 1'b0;
                    st_next   = ST_DECODE;
                end
            end
            ST_DECODE: begin
                // Data returns next cycle
                ra_next = dif.ra;
                rb_next = dif.rb;
                st_next = ST_EXEC;
            end
            ST_EXEC: begin
                st_next = ST_IDLE;
                rdy_next = 1'b1;
                if (dif.kind == K_FOREIGN) begin
                    frn_next = 1'b1;
                end else if (dif.kind == K_UNDEF) begin
                    und_next = 1'b1;
                end else if (!cond_reg) begin
                    // Skipped: no write, access or flag change
                    done_next = 1'b1;
                end else if (dif.kind == K_SHIFT) begin
                    rdwe_next = 1'b1;
                    rda_next  = dif.dest;
                    rdd_next  = sh_out;
                    fwe_next  = dif.set_flags;
                    fn_next   = sh_out[31];
                    fz_next   = (sh_out == RST_WORD);
                    fc_next   = sh_c;
                    done_next = 1'b1;
                end else begin
                    // Hold the access until acked
                    mreq_next = 1'b1;
                    madr_next = dif.index ? off_addr : base;
                    mw_next   = dif.load_word;
                    mu_next   = dif.unpriv;
                    off_addr_next = off_addr;
                    rdy_next  = 1'b0;
                    st_next   = ST_MEM;
                end
            end
            ST_MEM: begin
                if (mem_ack) begin
                    mreq_next = 1'b0;
                    rdwe_next = 1'b1;
                    rda_next  = dif.dest;
                    // Sign fill the low half
                    rdd_next  = mw_reg ? mem_rdata
                              : {{16{mem_rdata[15]}}, mem_rdata[15:0]};
                    wbwe_next = dif.wback;
                    wba_next  = ra_reg;
                    wbd_next  = off_addr_reg;
                    done_next = 1'b1;
                    rdy_next  = 1'b1;
                    st_next   = ST_IDLE;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Idle and ready, everything else cleared
            st_reg <= ST_IDLE;
            rdy_reg <= 1'b1;
            {ins_reg, pc_reg, off_addr_reg} <= {3{RST_WORD}};
            {rdd_reg, wbd_reg, madr_reg} <= {3{RST_WORD}};
            {ra_reg, rb_reg, rda_reg, wba_reg} <= 16'h0000;
            {is32_reg, cond_reg, it_reg, mext_reg, rdwe_reg, wbwe_reg} <= 6'h00;
            {fwe_reg, fn_reg, fz_reg, fc_reg, mreq_reg, mw_reg, mu_reg} <= 7'h00;
            {done_reg, und_reg, frn_reg} <= 3'h0;
        end else begin
            st_reg <= st_next;
            ins_reg <= ins_next;
            is32_reg <= is32_next;
            pc_reg <= pc_next;
            cond_reg <= cond_next;
            it_reg <= it_next;
            mext_reg <= mext_next;
            off_addr_reg <= off_addr_next;
            rdy_reg <= rdy_next;
            ra_reg <= ra_next;
            rb_reg <= rb_next;
            rdwe_reg <= rdwe_next;
            rda_reg <= rda_next;
            rdd_reg <= rdd_next;
            wbwe_reg <= wbwe_next;
            wba_reg <= wba_next;
            wbd_reg <= wbd_next;
            fwe_reg <= fwe_next;
            fn_reg <= fn_next;
            fz_reg <= fz_next;
            fc_reg <= fc_next;
            mreq_reg <= mreq_next;
            madr_reg <= madr_next;
            mw_reg <= mw_next;
            mu_reg <= mu_next;
            done_reg <= done_next;
            und_reg <= und_next;
            frn_reg <= frn_next;
        end
    end

    // Outputs straight from flops
    assign instr_ready = rdy_reg;
    assign rf_addr_a   = ra_reg;
    assign rf_addr_b   = rb_reg;
    assign rd_we       = rdwe_reg;
    assign rd_addr     = rda_reg;
    assign rd_data     = rdd_reg;
    assign wb_we       = wbwe_reg;
    assign wb_addr     = wba_reg;
    assign wb_data     = wbd_reg;
    assign flag_we     = fwe_reg;
    assign flag_n      = fn_reg;
    assign flag_z      = fz_reg;
    assign flag_c      = fc_reg;
    assign mem_req     = mreq_reg;
    assign mem_addr    = madr_reg;
    assign mem_word    = mw_reg;
    assign mem_unpriv  = mu_reg;
    assign done        = done_reg;
    assign undef       = und_reg;
    assign foreign     = frn_reg;
endmodule // lusld_core

// file: rtl/lusld_pkg.sv
// Constants and types of the load and shift block
package lusld_pkg;
    // Datapath widths
    localparam int unsigned XLEN      = 32;
    localparam int unsigned RIDX      = 4;
    // Data reset value
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    // Word-aligns the literal base
    localparam logic [31:0] ALIGN_MSK = 32'hffff_fffc;
    localparam logic [3:0]  REG_PC    = 4'hf;
    // Larger counts act alike
    localparam logic [7:0]  SHAMT_CAP = 8'h21;
    // 16-bit encodings
    localparam logic [6:0]  SH_LD_REG16 = 7'h2f;   // bits 15:9
    localparam logic [4:0]  SH_IMM16    = 5'h00;   // bits 15:11
    localparam logic [9:0]  SH_REG16    = 10'h102; // bits 15:6
    // 32-bit encodings, both halfwords
    localparam logic [11:0] SHALF_HW1   = 12'hf93; // bits 15:4
    localparam logic [11:0] WUNPRIV_HW1 = 12'hf85; // bits 15:4
    localparam logic [3:0]  UNPRIV_HW2  = 4'he;    // hw2 bits 11:8
    localparam logic [7:0]  SLIT_HI     = 8'hf9;   // bits 15:8
    localparam logic [6:0]  SLIT_LO     = 7'h3f;   // bits 6:0
    localparam logic [7:0]  WLIT_HI     = 8'hf8;
    localparam logic [6:0]  WLIT_LO     = 7'h5f;
    localparam logic [10:0] MOVI_HW1    = 11'h752; // bits 15:5
    localparam logic [8:0]  MOVR_HW1    = 9'h1f4;  // bits 15:7
    localparam logic [1:0]  SRT_LSL     = 2'h0;
    localparam logic [3:0]  MOVR_HW2HI  = 4'hf;
    localparam logic [3:0]  MOVR_HW2MID = 4'h0;
    // Decoded class
    typedef enum logic [1:0] {K_FOREIGN, K_UNDEF, K_LOAD, K_SHIFT}
        lusld_kind_e;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_EXEC, ST_MEM}
        lusld_state_e;
endpackage

// file: rtl/lusld_dec_if.sv
// Decode results, decoder to sequencer
`timescale 1ns/100ps
interface lusld_dec_if;
    import lusld_pkg::*;
    lusld_kind_e kind;        // Class
    logic        load_word;   // Word, else half
    logic        unpriv;      // User access
    logic        literal;     // Base is pc
    logic        add;         // Add, else subtract
    logic        index;       // Use offset address
    logic        wback;       // Base writeback
    logic        set_flags;   // Update flags
    logic        use_imm;     // Immediate offset
    logic        reg_amount;  // Count from port b
    logic [3:0]  dest;        // Destination
    logic [3:0]  ra;          // Base or source
    logic [3:0]  rb;          // Index or count
    logic [4:0]  amount;      // Shift count
    logic [11:0] imm;         // Byte offset
    modport dec  (output kind, load_word, unpriv, literal, add, index,
                  wback, set_flags, use_imm, reg_amount, dest, ra, rb,
                  amount, imm);
    modport core (input kind, load_word, unpriv, literal, add, index,
                  wback, set_flags, use_imm, reg_amount, dest, ra, rb,
                  amount, imm);
endinterface

// file: rtl/lusld_shifter.sv
// Left shifter for shifts and load index offsets
`timescale 1ns/100ps
module lusld_shifter
    import lusld_pkg::*;
(
    // Operand
    input  wire logic [31:0] value,
    input  wire logic [7:0]  amount,
    input  wire logic        carry_in,
    // Result
    output logic      [31:0] result,
    output logic             carry_out
);
    logic [7:0]  amt_cap;   // Clamped count
    logic [32:0] wide;      // Carry bit above the result

    // Zero fill, last bit out is carry
    always_comb begin
        amt_cap   = (amount > SHAMT_CAP) ? SHAMT_CAP : amount;
        wide      = {1'b0, value} << amt_cap;
        result    = wide[31:0];
        // A zero count leaves the carry as it was
        carry_out = (amount == 8'h00) ? carry_in : wide[32];
    end
endmodule // lusld_shifter

// file: rtl/lusld_decode.sv
// Decoder for the load and shift group
`timescale 1ns/100ps
module lusld_decode
    import lusld_pkg::*;
(
    // Instruction
    input  wire logic [31:0] instr,
    input  wire logic        is_32,
    input  wire logic        in_it_block,
    input  wire logic        main_ext,
    // Results
    lusld_dec_if.dec         d
);
    logic [15:0] h1;   // First halfword of a 32-bit form
    logic [15:0] h2;   // Second halfword, or the 16-bit form

    // Pattern match, most specific first
    always_comb begin
        h1           = instr[31:16];
        h2           = instr[15:0];
        d.kind       = K_FOREIGN;
        d.load_word  = 1'b0;
        d.unpriv     = 1'b0;
        d.literal    = 1'b0;
        d.add        = 1'b1;
        d.index      = 1'b1;
        d.wback      = 1'b0;
        d.set_flags  = 1'b0;
        d.use_imm    = 1'b0;
        d.reg_amount = 1'b0;
        d.dest       = h2[15:12];
        d.ra         = h1[3:0];
        d.rb         = h2[3:0];
        d.amount     = 5'h00;
        d.imm        = 12'h000;
        if (!is_32) begin
            if (h2[15:9] == SH_LD_REG16) begin
                // Register offset load, no shift
                d.kind = K_LOAD;
                d.dest = {1'b0, h2[2:0]};
                d.ra   = {1'b0, h2[5:3]};
                d.rb   = {1'b0, h2[8:6]};
            end else if (h2[15:11] == SH_IMM16 && h2[10:6] != 5'h00) begin
                // Count 1..31, zero field is a plain move
                d.kind      = K_SHIFT;
                d.amount    = h2[10:6];
                d.dest      = {1'b0, h2[2:0]};
                d.ra        = {1'b0, h2[5:3]};
                d.set_flags = !in_it_block;
            end else if (h2[15:6] == SH_REG16) begin
                // Source register and destination share fields
                d.kind       = K_SHIFT;
                d.reg_amount = 1'b1;
                d.dest       = {1'b0, h2[2:0]};
                d.ra         = {1'b0, h2[2:0]};
                d.rb         = {1'b0, h2[5:3]};
                d.set_flags  = !in_it_block;
            end
        end else begin
            if ((h1[15:8] == SLIT_HI && h1[6:0] == SLIT_LO) ||
                (h1[15:8] == WLIT_HI && h1[6:0] == WLIT_LO)) begin
                // All-ones base means literal
                if (h2[15:12] != REG_PC) begin
                    d.kind      = K_LOAD;
                    d.literal   = 1'b1;
                    d.load_word = (h1[15:8] == WLIT_HI);
                    d.add       = h1[7];
                    d.use_imm   = 1'b1;
                    d.imm       = h2[11:0];
                end
            end else if (h1[15:4] == SHALF_HW1 &&
                         h2[11:6] == 6'h00 && h2[15:12] != REG_PC) begin
                d.kind   = K_LOAD;
                d.amount = {3'h0, h2[5:4]};
            end else if ((h1[15:4] == SHALF_HW1 ||
                          h1[15:4] == WUNPRIV_HW1) &&
                         h2[11:8] == UNPRIV_HW2) begin
                // Always added, never written back
                d.kind      = K_LOAD;
                d.unpriv    = 1'b1;
                d.load_word = (h1[15:4] == WUNPRIV_HW1);
                d.use_imm   = 1'b1;
                d.imm       = {4'h0, h2[7:0]};
            end else if (h1[15:5] == MOVI_HW1 && h1[3:0] == REG_PC &&
                         h2[15] == 1'b0 && h2[5:4] == SRT_LSL &&
                         {h2[14:12], h2[7:6]} != 5'h00) begin
                d.kind      = K_SHIFT;
                d.amount    = {h2[14:12], h2[7:6]};
                d.dest      = h2[11:8];
                d.ra        = h2[3:0];
                d.set_flags = h1[4];
            end else if (h1[15:7] == MOVR_HW1 && h1[6:5] == SRT_LSL &&
                         h2[15:12] == MOVR_HW2HI &&
                         h2[7:4] == MOVR_HW2MID) begin
                d.kind       = K_SHIFT;
                d.reg_amount = 1'b1;
                d.dest       = h2[11:8];
                d.ra         = h1[3:0];
                d.rb         = h2[3:0];
                d.set_flags  = h1[4];
            end
            // Wide forms need the main extension
            if (!main_ext && d.kind != K_FOREIGN) begin
                d.kind = K_UNDEF;
            end
        end
    end
endmodule // lusld_decode

// file: testbench/lusld_core_chk.sv
// Port assertions, load and shift block
`timescale 1ns/100ps
module lusld_core_chk
    import lusld_pkg::*;
(
    // Watched ports
    input wire logic        ref_clk, rst, instr_valid, instr_ready,
    input wire logic        instr_is_32, cond_pass, main_extension_present,
    input wire logic        rd_we, flag_we, flag_n, flag_z, done, undef,
    input wire logic        foreign, mem_req, mem_word, mem_unpriv, mem_ack,
    input wire logic        wb_we,
    input wire logic [31:0] instr_word, rf_data_a, rd_data, mem_rdata,
    input wire logic [31:0] mem_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Offered fields and returned half
    wire [7:0]  imm  = instr_word[7:0];
    wire [4:0]  amt  = instr_word[10:6];
    wire [15:0] half = mem_rdata[15:0];
    wire        tk   = instr_valid && instr_ready;
    // Wide unpriv load, real base, passed
    wire up = tk && instr_is_32 && instr_word[11:8] == UNPRIV_HW2 &&
        instr_word[19:16] != REG_PC && cond_pass &&
        (instr_word[31:20] == SHALF_HW1 || instr_word[31:20] == WUNPRIV_HW1);
    // Narrow immediate shift, passed
    wire sh = tk && !instr_is_32 && instr_word[15:11] == SH_IMM16 && cond_pass;
    a_unpriv_kind: assert property (up && main_extension_present
        |-> ##3 mem_req && mem_unpriv && mem_word == !$past(instr_word[24], 3))
        else $error("unpriv kind wrong");
    a_unpriv_addr: assert property (up && main_extension_present
        |-> ##3 mem_addr == $past(rf_data_a) + $past(imm, 3))
        else $error("unpriv address wrong");
    a_wide_undef: assert property (up && !main_extension_present
        |-> ##3 undef) else $error("wide load not undefined");
    a_shift_imm: assert property (sh && amt != 5'h00
        |-> ##3 rd_we && rd_data == $past(rf_data_a) << $past(amt, 3))
        else $error("shift result wrong");
    a_zero_count: assert property (sh && amt == 5'h00 |-> ##3 foreign)
        else $error("zero count not foreign");
    a_req_stable: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr) && $stable(mem_unpriv))
        else $error("request changed early");
    a_half_extend: assert property (mem_req && mem_ack && !mem_word
        |=> rd_we && done && rd_data == {{16{$past(half[15])}}, $past(half)})
        else $error("half not sign extended");
    a_no_writeback: assert property (mem_req && mem_ack |=> !wb_we)
        else $error("base written back");
    a_flags_result: assert property (flag_we
        |-> flag_z == (rd_data == 32'h0) && flag_n == rd_data[31])
        else $error("flags disagree");
    a_cond_quiet: assert property (tk && !cond_pass
        |=> (!rd_we && !flag_we && !mem_req && !wb_we) [*3])
        else $error("failed condition wrote");
endmodule // lusld_core_chk
bind lusld_core lusld_core_chk lusld_core_chk_inst (.*);

// file: testbench/lusld_partner.sv
// Register file and memory port model
`timescale 1ns/100ps
module lusld_partner (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register reads and memory requests
    input  wire logic [3:0]  rf_addr_a, rf_addr_b,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic      [31:0] rf_data_a, rf_data_b, mem_rdata,
    output logic             mem_ack
);
    logic [31:0] rf [16]; // Loaded by the bench
    int          wait_cnt; // Wait before next answer
    assign rf_data_a = rf[rf_addr_a];
    assign rf_data_b = rf[rf_addr_b];
    // Acks after 0..3 cycles; data toggles when idle
    always @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt  <= 0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && wait_cnt == 0) begin
                mem_ack   <= 1'b1;
                mem_rdata <= {~mem_addr[31:16], mem_addr[15:0] ^ 16'h8001};
                wait_cnt  <= $urandom % 4;
            end else if (mem_req) wait_cnt <= wait_cnt - 1;
        end
    end
endmodule // lusld_partner

// file: testbench/lusld_core_tb.sv
// Random and corner-case bench, load and shift block
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin \
    err_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module lusld_core_tb;
    import lusld_pkg::*;
    // Inputs, driven at the falling edge
    logic        ref_clk = 0, rst = 1, instr_valid = 0, instr_is_32 = 0;
    logic        cond_pass = 1, in_it_block = 0, carry_flag = 0;
    logic        main_extension_present = 1;
    logic [31:0] instr_word = 0, instr_pc = 0;
    // Outputs
    logic        instr_ready, rd_we, wb_we, flag_we, flag_n, flag_z, flag_c;
    logic        mem_req, mem_word, mem_unpriv, mem_ack, done, undef, foreign;
    logic [31:0] rf_data_a, rf_data_b, rd_data, wb_data, mem_addr, mem_rdata;
    logic [3:0]  rf_addr_a, rf_addr_b, rd_addr, wb_addr, rn;
    // Corner counts come first
    logic [7:0]  cnt_tbl [6] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};
    logic [31:0] r, v, sa, w, a;
    logic [32:0] e;
    logic [15:0] h;
    logic [7:0]  n8;
    logic        sw, su, wide, fl, wd, up;
    int          err_count = 0, compares = 0, i, k;
    always #2 ref_clk = ~ref_clk;
    lusld_core    lusld_core_inst (.*);
    lusld_partner lusld_partner_inst (.*);
    // Left shift, carry out on top
    function automatic logic [32:0] shl(logic [31:0] x, logic [7:0] c);
        shl = c == 0 ? {carry_flag, x} : c > 32 ? 33'h0 : {x, 1'b0} << (c - 1);
    endfunction
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Offer one instruction, wait a bounded time
    task automatic run();
        int t;
        @(negedge ref_clk);
        instr_word  = w;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        for (t = 0; t < 40 && (done | undef | foreign) !== 1'b1; t++) begin
            if (mem_req === 1'b1) begin
                sa = mem_addr;
                sw = mem_word;
                su = mem_unpriv;
            end
            @(negedge ref_clk);
        end
        `CHK("finish", 1'b1, t < 40)
        if (wide && !main_extension_present && cond_pass)
            `CHK("undef", 1'b1, undef)
    endtask
    // Watchdog, far beyond the run length
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(20098));
        for (i = 0; i < 16; i++) lusld_partner_inst.rf[i] = $urandom;
        repeat (20) @(negedge ref_clk);
        rst = 0;
        for (i = 0; i < 360; i++) begin
            r = $urandom;
            k = i % 6;
            n8 = i < 36 ? cnt_tbl[i / 6] : r[7:0];
            wide = k inside {1, 3, 4} || (k == 5 && r[31]);
            instr_is_32 = wide;
            cond_pass = r[28:26] != 3'h0;
            main_extension_present = r[25:23] != 3'h0;
            in_it_block = main_extension_present & r[22];
            carry_flag = r[21];
            instr_pc = $urandom;
            if (k == 2 || k == 3) lusld_partner_inst.rf[r[2:0]][7:0] = n8;
            v = lusld_partner_inst.rf[k < 2 ? r[2:0] : r[5:3]];
            fl = k % 2 ? r[31] : !in_it_block;
            rn = r[30:29] == 2'h3 ? REG_PC : {1'b0, r[13:11]};
            wd = k == 4 && r[31];
            up = k == 4 && rn != REG_PC;
            a = rn == REG_PC ? (instr_pc & ALIGN_MSK) - {UNPRIV_HW2, n8}
                : lusld_partner_inst.rf[rn] + n8;
            // Destinations r0..r7, never 13 or 15
            case (k)
                0: w = {16'h0, SH_IMM16, n8[4:0], r[2:0], r[5:3]};
                1: w = {MOVI_HW1, r[31], 4'hf, 1'b0, n8[4:2], 1'b0, r[5:3],
                        n8[1:0], SRT_LSL, 1'b0, r[2:0]};
                2: w = {16'h0, SH_REG16, r[2:0], r[5:3]};
                3: w = {MOVR_HW1, SRT_LSL, r[31], 1'b0, r[5:3], MOVR_HW2HI,
                        1'b0, r[5:3], MOVR_HW2MID, 1'b0, r[2:0]};
                4: w = {r[31] ? WUNPRIV_HW1 : SHALF_HW1, rn, 1'b0, r[17:15],
                        UNPRIV_HW2, n8};
                default: begin
                    // Wide form shifts the index by 0..3
                    w = wide ? {SHALF_HW1, 1'b0, r[13:11], 1'b0, r[17:15],
                        6'h00, r[10:9], 1'b0, r[8:6]}
                        : {16'h0, SH_LD_REG16, r[8:6], r[13:11], r[17:15]};
                    v = lusld_partner_inst.rf[r[8:6]];
                    a = lusld_partner_inst.rf[r[13:11]]
                        + (v << (wide ? r[10:9] : 2'h0));
                end
            endcase
            run();
            if (wide && !main_extension_present) continue;
            `CHK("write", cond_pass && !(k < 2 && n8[4:0] == 0), rd_we)
            if (cond_pass && k < 2 && n8[4:0] == 5'h00)
                `CHK("foreign", 1'b1, foreign)
            else if (cond_pass && k < 4) begin
                e = shl(v, k < 2 ? {3'h0, n8[4:0]} : n8);
                `CHK("shift", e[31:0], rd_data)
                `CHK("flags", {fl, e[32] | !fl}, {flag_we, flag_c | !fl})
                `CHK("dest", {1'b0, r[5:3]}, rd_addr)
            end else if (cond_pass) begin
                h = a[15:0] ^ 16'h8001;
                `CHK("addr", a, sa)
                `CHK("access", {wd, up}, {sw, su})
                `CHK("data", wd ? {~a[31:16], h} : {{16{h[15]}}, h}, rd_data)
                `CHK("dest", {1'b0, r[17:15]}, rd_addr)
                `CHK("wback", 1'b0, wb_we)
            end
        end
        finish_test();
    end
endmodule // lusld_core_tb
